// >>> rtl/wsrc_pkg.sv
package wsrc_pkg;
    // ************************************************************
    // ring sizes
    // ************************************************************
    localparam int WSRC_SW_STAGES = 32;
    localparam int WSRC_ED_STAGES = 16;
    localparam int WSRC_WL_STAGES = 12;
    localparam int WSRC_LINES = 512;
    localparam int WSRC_SENSE_PER_GROUP = 16;
    localparam int WSRC_SENSE_TOTAL = 192;
    localparam int WSRC_SW_W = 5;
    localparam int WSRC_ED_W = 4;
    localparam int WSRC_LINE_W = 9;
    localparam int WSRC_WL_W = 4;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int WSRC_CLK_MHZ = 250;
    localparam int WSRC_WORD_CUR_NS = 150;
    // approximate width: integer division truncates 37.5 to 37 cycles, i.e. 148 ns
    localparam int WSRC_WORD_CUR_CYC = (WSRC_WORD_CUR_NS * WSRC_CLK_MHZ) / 1000;
    localparam int WSRC_CNT_W = 8;
    localparam logic [WSRC_CNT_W-1:0] WSRC_CNT_ZERO = 8'h00;
    localparam logic [WSRC_CNT_W-1:0] WSRC_CNT_ONE = 8'h01;
    localparam logic [WSRC_CNT_W-1:0] WSRC_CNT_LOAD = WSRC_CNT_W'(WSRC_WORD_CUR_CYC);
    // ************************************************************
    // reset values: first stage active
    // ************************************************************
    localparam logic [WSRC_SW_STAGES-1:0] WSRC_SW_FIRST = 32'h0000_0001;
    localparam logic [WSRC_ED_STAGES-1:0] WSRC_ED_FIRST = 16'h0001;
    localparam logic [WSRC_WL_STAGES-1:0] WSRC_WL_FIRST = 12'h001;
endpackage

// >>> rtl/wsrc_ring.sv
`timescale 1ns/1ns
module wsrc_ring #(
    parameter int N = 4,
    parameter logic [N-1:0] FIRST = N'(1)
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    wsrc_ring_if.ring rif
);
    typedef struct packed {
        logic [N-1:0] stg;
    } wsrc_ring_st_t;

    wsrc_ring_st_t st_r;
    wsrc_ring_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (rif.clear) begin
            st_nxt.stg = FIRST; // R5 R15
        end else if (rif.step) begin
            // rotate left: last stage wraps to first, one-hot kept
            st_nxt.stg = {st_r.stg[N-2:0], st_r.stg[N-1]}; // R9 R20
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r.stg <= FIRST; // R5
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.stages = st_r.stg; // R3
endmodule

// >>> rtl/wsrc_ring_if.sv
`timescale 1ns/1ns
interface wsrc_ring_if #(parameter int N = 4);
    logic clear;
    logic step;
    logic [N-1:0] stages;
    modport ctl (output clear, output step, input stages);
    modport ring (input clear, input step, output stages);
endinterface

// >>> rtl/wsrc_top.sv
`timescale 1ns/1ns
// Summary of operation
// R1: each line holds twelve words, ring-selected
// R2: 32 switches times 16 drivers give 512
// R3: each set has its own driving ring
// R4: controller pulses clear and set together
// R5: clear leaves only first stage active
// R6: power pulse grounds selected switch group
// R7: controller holds power pulse 500 ns
// R8: step only after power pulse ends
// R9: step moves activation to next stage
// R10: word current only during power pulse
// R11: word current pulse lasts about 150 ns
// R12: unselected edge drivers stay off
// R13: 12-stage ring enables 16 of 192
// R14: steps no faster than 160 us (top does not limit step rate; model waits only GAP = 10 cycles after a step)
// R15: set/clear returns all three rings
// R16: regulators pulsed only around selection
// R17: controller resets data flip-flops each cycle (model never drives data_reg_reset; test pulses it once)
// R18: data flip-flop holds bit until written
// R19: second bit clock follows the first
// R20: last stage wraps back to first
// R21: controller clears rings before a pass (model drives no ring clears; test clears once, mid-run)
module wsrc_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sw_clear,
    input wire logic sw_set,
    input wire logic ed_clear,
    input wire logic ed_set,
    input wire logic wl_clear,
    input wire logic wl_set,
    input wire logic power_pulse_input,
    input wire logic step_pulse_input,
    input wire logic word_current_request,
    input wire logic data_reg_reset,
    input wire logic data_reg_load,
    input wire logic data_in,
    output logic [wsrc_pkg::WSRC_SW_STAGES-1:0] word_group_ground_driver,
    output logic [wsrc_pkg::WSRC_ED_STAGES-1:0] edge_drive,
    output logic [wsrc_pkg::WSRC_WL_STAGES-1:0] sense_group_enable,
    output logic [wsrc_pkg::WSRC_LINE_W-1:0] line_index,
    output logic [wsrc_pkg::WSRC_WL_W-1:0] word_index,
    output logic word_current_active,
    output logic data_bit
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] wsrc_onehot_idx(input logic [31:0] v);
        logic [7:0] idx;
        idx = 8'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                idx = 8'(i);
            end
        end
        return idx;
    endfunction

    // ************************************************************
    // rings
    // ************************************************************
    wsrc_ring_if #(.N(wsrc_pkg::WSRC_SW_STAGES)) sw_if ();
    wsrc_ring_if #(.N(wsrc_pkg::WSRC_ED_STAGES)) ed_if ();
    wsrc_ring_if #(.N(wsrc_pkg::WSRC_WL_STAGES)) wl_if ();

    // clear acts only with both clear and set pulsed; step is
    // masked during the power pulse so a stray step cannot shift
    // the selection under a live word line
    assign sw_if.clear = sw_clear & sw_set; // R4 R15
    assign ed_if.clear = ed_clear & ed_set; // R4 R15
    assign wl_if.clear = wl_clear & wl_set; // R4 R15
    assign sw_if.step = step_pulse_input & ~power_pulse_input; // R8
    assign ed_if.step = step_pulse_input & ~power_pulse_input; // R8
    assign wl_if.step = step_pulse_input & ~power_pulse_input; // R8

    wsrc_ring #(.N(wsrc_pkg::WSRC_SW_STAGES), .FIRST(wsrc_pkg::WSRC_SW_FIRST)) u_sw (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rif(sw_if)
    );
    wsrc_ring #(.N(wsrc_pkg::WSRC_ED_STAGES), .FIRST(wsrc_pkg::WSRC_ED_FIRST)) u_ed (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rif(ed_if)
    );
    wsrc_ring #(.N(wsrc_pkg::WSRC_WL_STAGES), .FIRST(wsrc_pkg::WSRC_WL_FIRST)) u_wl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rif(wl_if)
    );

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        WSRC_IDLE,
        WSRC_CUR,
        WSRC_WAIT
    } wsrc_cur_state_t;

    typedef struct packed {
        wsrc_cur_state_t cst;
        logic [wsrc_pkg::WSRC_CNT_W-1:0] cnt;
        logic cur;
        logic [wsrc_pkg::WSRC_SW_STAGES-1:0] gnd;
        logic [wsrc_pkg::WSRC_ED_STAGES-1:0] edv;
        logic [wsrc_pkg::WSRC_WL_STAGES-1:0] sen;
        logic [wsrc_pkg::WSRC_LINE_W-1:0] line;
        logic [wsrc_pkg::WSRC_WL_W-1:0] word;
        logic dbit;
    } wsrc_state_t;

    wsrc_state_t st_r;
    wsrc_state_t st_nxt;

    always_comb begin
        logic [7:0] sw_i;
        logic [7:0] ed_i;
        logic [7:0] wl_i;
        sw_i = wsrc_onehot_idx(32'(sw_if.stages));
        ed_i = wsrc_onehot_idx(32'(ed_if.stages));
        wl_i = wsrc_onehot_idx(32'(wl_if.stages));
        st_nxt = st_r;
        // word current pulse: started by request inside power pulse,
        // fixed length unless the power pulse ends first, one per power pulse
        unique case (st_r.cst)
            WSRC_IDLE: begin
                if (power_pulse_input && word_current_request) begin // R10
                    st_nxt.cst = WSRC_CUR;
                    st_nxt.cnt = wsrc_pkg::WSRC_CNT_LOAD; // R11
                end
            end
            WSRC_CUR: begin
                if (st_r.cnt == wsrc_pkg::WSRC_CNT_ONE || !power_pulse_input) begin // R11
                    st_nxt.cst = WSRC_WAIT;
                    st_nxt.cnt = wsrc_pkg::WSRC_CNT_ZERO;
                end else begin
                    st_nxt.cnt = st_r.cnt - wsrc_pkg::WSRC_CNT_ONE;
                end
            end
            WSRC_WAIT: begin
                if (!power_pulse_input) begin
                    st_nxt.cst = WSRC_IDLE;
                end
            end
        endcase
        st_nxt.cur = (st_nxt.cst == WSRC_CUR);
        // ground only the active switch group while powered
        st_nxt.gnd = power_pulse_input ? sw_if.stages : '0; // R6 R2
        // only the selected edge stage conducts, others held off
        st_nxt.edv = st_nxt.cur ? ed_if.stages : '0; // R12 R10
        st_nxt.sen = wl_if.stages; // R13 R1
        // line = driver * 32 + switch gives one of 512
        st_nxt.line = {ed_i[wsrc_pkg::WSRC_ED_W-1:0], sw_i[wsrc_pkg::WSRC_SW_W-1:0]}; // R2
        st_nxt.word = wl_i[wsrc_pkg::WSRC_WL_W-1:0]; // R1
        // data bit held until controller loads or resets it; reset wins
        if (data_reg_reset) begin
            st_nxt.dbit = 1'b0;
        end else if (data_reg_load) begin
            st_nxt.dbit = data_in; // R18
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.cst <= WSRC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_group_ground_driver = st_r.gnd;
    assign edge_drive = st_r.edv;
    assign sense_group_enable = st_r.sen;
    assign line_index = st_r.line;
    assign word_index = st_r.word;
    assign word_current_active = st_r.cur;
    assign data_bit = st_r.dbit;
endmodule

// >>> tb/wsrc_ctl_model.sv
`timescale 1ns/1ns
module wsrc_ctl_model #(
    parameter int GAP = 10
) (
    input wire logic sys_clk,
    input wire logic go,
    output logic power_pulse_input,
    output logic step_pulse_input,
    output logic word_current_request,
    output logic busy
);
    initial begin
        {power_pulse_input, step_pulse_input, word_current_request, busy} = 4'h0;
    end
    // one selection cycle per go; GAP stands in for the long step spacing
    always begin
        @(posedge sys_clk);
        if (go) begin
            busy <= 1'b1;
            power_pulse_input <= 1'b1;
            word_current_request <= 1'b1;
            @(posedge sys_clk);
            word_current_request <= 1'b0;
            repeat (124) @(posedge sys_clk);
            power_pulse_input <= 1'b0;
            @(posedge sys_clk);
            step_pulse_input <= 1'b1;
            @(posedge sys_clk);
            step_pulse_input <= 1'b0;
            repeat (GAP) @(posedge sys_clk);
            busy <= 1'b0;
        end
    end
endmodule

// >>> tb/wsrc_monitor.sv
`timescale 1ns/1ns
module wsrc_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wl_clear,
    input wire logic wl_set,
    input wire logic power_pulse_input,
    input wire logic step_pulse_input,
    input wire logic word_current_request,
    input wire logic data_reg_reset,
    input wire logic data_reg_load,
    input wire logic data_in,
    input wire logic [31:0] word_group_ground_driver,
    input wire logic [15:0] edge_drive,
    input wire logic [8:0] line_index,
    input wire logic [3:0] word_index,
    input wire logic word_current_active,
    input wire logic data_bit
);
    // ****
    // word-current length counter, cleared while the pulse is low
    // ****
    logic [7:0] cnt_r;
    always_ff @(posedge sys_clk) cnt_r <= (!rst_n || !word_current_active) ? 8'h00 : cnt_r + 8'h01;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_GND_OFF: assert property (!$past(power_pulse_input) |-> word_group_ground_driver == 32'h0)
        else $error("ground driver on without power");
    AST_GND_SEL: assert property ($past(power_pulse_input) |->
        word_group_ground_driver == 32'h1 << line_index[4:0]) else $error("wrong ground group");
    AST_ED_SEL: assert property (edge_drive == (word_current_active ? 16'h1 << line_index[8:5] : 16'h0))
        else $error("wrong edge stage");
    AST_WC_MAX: assert property (word_current_active |-> cnt_r < 8'h25)
        else $error("word current too long");
    AST_WC_LEN: assert property ($fell(word_current_active) && power_pulse_input |-> cnt_r == 8'h25)
        else $error("word current too short");
    AST_WC_GO: assert property (power_pulse_input && word_current_request && !word_current_active |=>
        word_current_active) else $error("word current not started");
    AST_STEP: assert property (step_pulse_input && !power_pulse_input && !wl_clear |-> ##2
        word_index == ($past(word_index, 2) == 4'hB ? 4'h0 : $past(word_index, 2) + 4'h1)) else $error("bad step");
    AST_CLR: assert property (wl_clear && wl_set |-> ##2 word_index == 4'h0)
        else $error("clear missed");
    AST_DATA: assert property (data_reg_reset || data_reg_load |=>
        data_bit == (!$past(data_reg_reset) && $past(data_in))) else $error("data bit wrong");
    cover property ($fell(word_current_active));
    cover property (step_pulse_input && word_index == 4'hB);
    cover property (wl_clear && wl_set);
endmodule
bind wsrc_top wsrc_monitor wsrc_monitor_i (.sys_clk, .rst_n, .wl_clear, .wl_set, .power_pulse_input,
    .step_pulse_input, .word_current_request, .data_reg_reset, .data_reg_load, .data_in,
    .word_group_ground_driver, .edge_drive, .line_index, .word_index, .word_current_active, .data_bit);

// >>> tb/wsrc_top_test.sv
`timescale 1ns/1ns
module wsrc_top_test;
    logic sys_clk, rst_n, sw_clear, sw_set, ed_clear, ed_set, wl_clear, wl_set, go, busy;
    logic power_pulse_input, step_pulse_input, word_current_request, data_reg_reset, data_reg_load, data_in;
    logic [31:0] word_group_ground_driver;
    logic [15:0] edge_drive;
    logic [11:0] sense_group_enable;
    logic [8:0] line_index;
    logic [3:0] word_index;
    logic word_current_active, data_bit;
    logic [1:0] bit_clk;
    int mismatches, n_tests, k, n;
    wsrc_top wsrc_top_i (.sys_clk, .rst_n, .sw_clear, .sw_set, .ed_clear, .ed_set, .wl_clear, .wl_set,
        .power_pulse_input, .step_pulse_input, .word_current_request, .data_reg_reset, .data_reg_load, .data_in,
        .word_group_ground_driver, .edge_drive, .sense_group_enable, .line_index, .word_index,
        .word_current_active, .data_bit);
    wsrc_ctl_model #(.GAP(10)) wsrc_ctl_model_i (.sys_clk, .go, .power_pulse_input, .step_pulse_input,
        .word_current_request, .busy);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one full selection cycle; counts word-current cycles into n
    task automatic sel();
        int i;
        n = 0;
        @(posedge sys_clk) go <= 1'b1;
        @(posedge sys_clk) go <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge sys_clk);
            if (i == 5) chk(word_group_ground_driver === 32'h1 << (k % 32), "ground group");
            if (i == 5) chk(edge_drive === 16'h1 << (k % 16), "edge stage");
            if (word_current_active === 1'b1) n++;
            if (busy === 1'b0) break;
        end
        k++;
        // a hung controller counts as a mismatch and ends the run here
        if (i == 300) begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic rings(input logic s);
        @(posedge sys_clk) {sw_clear, ed_clear, wl_clear, sw_set, ed_set, wl_set} <= {3'h7, {3{s}}};
        @(posedge sys_clk) {sw_clear, ed_clear, wl_clear, sw_set, ed_set, wl_set} <= 6'h00;
        repeat (3) @(negedge sys_clk);
    endtask
    initial begin
        {rst_n, sw_clear, sw_set, ed_clear, ed_set, wl_clear, wl_set, go} = 8'h00;
        {data_reg_reset, data_reg_load, data_in} = 3'h0;
        bit_clk = 2'h0;
        {mismatches, n_tests, k} = {32'h0, 32'h0, 32'h0};
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(sense_group_enable === 12'h001 && line_index === 9'h000 && word_index === 4'h0, "reset stage");
        $display("test reset done");
        sel();
        chk(n === 37, "word current length");
        chk(line_index === {4'h1, 5'h01} && word_index === 4'h1, "step");
        $display("test step done");
        repeat (15) sel();
        chk(line_index === {4'h0, 5'h10} && word_index === 4'h4, "wrap");
        chk(sense_group_enable === 12'h010, "sense group");
        $display("test wrap done");
        rings(1'b0);
        chk(word_index === 4'h4 && line_index === {4'h0, 5'h10}, "clear without set");
        rings(1'b1);
        chk(line_index === 9'h000 && sense_group_enable === 12'h001, "clear");
        k = 0;
        sel();
        $display("test clear done");
        @(posedge sys_clk) {data_reg_load, data_in} <= 2'h3;
        @(posedge sys_clk) {data_reg_load, data_in} <= 2'h0;
        repeat (3) @(negedge sys_clk);
        chk(data_bit === 1'b1, "data hold");
        // the second bit clock follows the first at once; the bit must stand through both
        @(posedge sys_clk) bit_clk <= 2'h1;
        @(negedge sys_clk) chk(data_bit === 1'b1 && bit_clk === 2'h1, "bit clock 1");
        @(posedge sys_clk) bit_clk <= 2'h2;
        @(negedge sys_clk) chk(data_bit === 1'b1 && bit_clk === 2'h2, "bit clock 2");
        @(posedge sys_clk) bit_clk <= 2'h0;
        @(posedge sys_clk) {data_reg_reset, data_reg_load, data_in} <= 3'h7;
        @(posedge sys_clk) {data_reg_reset, data_reg_load, data_in} <= 3'h0;
        @(negedge sys_clk);
        chk(data_bit === 1'b0, "data reset");
        $display("test data done");
        // reset from a non-first position must bring every ring back to its first stage
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(line_index === 9'h000 && word_index === 4'h0 && sense_group_enable === 12'h001, "mid-run reset");
        $display("test mid-run reset done");
        stop_test();
    end
endmodule
